/* core/p3s_defs.svh */
// Constants for the third-enable-pin select register pair.
// Assumes it is included by bare name from core/ sources.
`ifndef P3S_DEFS_SVH
`define P3S_DEFS_SVH

`define P3S_ADDR_W 8
`define P3S_DATA_W 8
`define P3S_LINREG_W 8
`define P3S_CONV_W 6
`define P3S_ADDR_LINREG 8'h33
`define P3S_ADDR_CONV 8'h34
`define P3S_RST_LINREG 8'h00
`define P3S_RST_CONV 6'h00
`define P3S_RSVD_BITS 2'h0
`define P3S_RD_UNMAPPED 8'h00

`endif

/* core/p3s_otp_load.sv */
// Default loader: brings the factory-programmed select defaults into the clock
// domain after reset release and issues one load pulse.
// Assumes the one-time memory word is static while the device runs.
`timescale 1ns/1ps
`default_nettype none
`include "p3s_defs.svh"

module p3s_otp_load (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [`P3S_LINREG_W-1:0] otp_linreg_i,
  input wire logic [`P3S_CONV_W-1:0] otp_conv_i,
  output logic [`P3S_LINREG_W-1:0] def_linreg_o,
  output logic [`P3S_CONV_W-1:0] def_conv_o,
  output logic load_o,
  output logic done_o
);

  p3s_pkg::p3s_load_state_t state_q, state_d;
  logic [`P3S_LINREG_W-1:0] lin_s1_q, lin_s2_q;
  logic [`P3S_CONV_W-1:0] conv_s1_q, conv_s2_q;

  // The fuse word comes from outside this clock, so two flops settle it
  // before the apply state lets anybody read it.
  always_comb begin
    case (state_q)
      p3s_pkg::P3S_LD_CAPTURE: state_d = p3s_pkg::P3S_LD_SETTLE;
      p3s_pkg::P3S_LD_SETTLE: state_d = p3s_pkg::P3S_LD_APPLY;
      p3s_pkg::P3S_LD_APPLY: state_d = p3s_pkg::P3S_LD_DONE;
      p3s_pkg::P3S_LD_DONE: state_d = p3s_pkg::P3S_LD_DONE;
      default: state_d = p3s_pkg::P3S_LD_CAPTURE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= p3s_pkg::P3S_LD_CAPTURE;
      lin_s1_q <= `P3S_RST_LINREG;
      lin_s2_q <= `P3S_RST_LINREG;
      conv_s1_q <= `P3S_RST_CONV;
      conv_s2_q <= `P3S_RST_CONV;
    end else begin
      state_q <= state_d;
      lin_s1_q <= otp_linreg_i;
      lin_s2_q <= lin_s1_q;
      conv_s1_q <= otp_conv_i;
      conv_s2_q <= conv_s1_q;
    end
  end

  assign def_linreg_o = lin_s2_q;
  assign def_conv_o = conv_s2_q;
  assign load_o = (state_q == p3s_pkg::P3S_LD_APPLY);
  assign done_o = (state_q == p3s_pkg::P3S_LD_DONE);

endmodule
`default_nettype wire

/* core/p3s_pkg.sv */
// Types used by the default loader of the select register pair.
// Assumes no other package.
`default_nettype none
package p3s_pkg;

  typedef enum logic [1:0] {
    P3S_LD_CAPTURE = 2'b00,
    P3S_LD_SETTLE = 2'b01,
    P3S_LD_APPLY = 2'b10,
    P3S_LD_DONE = 2'b11
  } p3s_load_state_t;

endpackage
`default_nettype wire

/* core/p3s_regs.sv */
// Select register pair for the third enable pin: one register for linear
// regulators 1 to 8, one for the step-down converters and linear regulators 9 and 10.
// Assumes the serial interface decoder drives the access port on CLK_I.
`timescale 1ns/1ps
`default_nettype none
`include "p3s_defs.svh"

module p3s_regs (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic [`P3S_ADDR_W-1:0] ADDR_I,
  input wire logic WR_I,
  input wire logic [`P3S_DATA_W-1:0] WDATA_I,
  input wire logic RD_I,
  input wire logic [`P3S_LINREG_W-1:0] OTP_LINREG_I,
  input wire logic [`P3S_CONV_W-1:0] OTP_CONV_I,
  output logic [`P3S_DATA_W-1:0] RDATA_O,
  output logic READY_O,
  output logic [`P3S_LINREG_W-1:0] LINREG_PIN3_SEL_O,
  output logic [`P3S_CONV_W-1:0] CONV_PIN3_SEL_O
);

  // ***********************************************************************
  // Default loading
  // ***********************************************************************

  logic [`P3S_LINREG_W-1:0] def_linreg;
  logic [`P3S_CONV_W-1:0] def_conv;
  logic load;
  logic done;

  // READY_O lags the loader's done flag by one edge, so software that waits
  // for READY_O never meets the window in which writes are dropped.
  p3s_otp_load u_load (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .otp_linreg_i(OTP_LINREG_I),
    .otp_conv_i(OTP_CONV_I),
    .def_linreg_o(def_linreg),
    .def_conv_o(def_conv),
    .load_o(load),
    .done_o(done)
  );

  // ***********************************************************************
  // Register state
  // ***********************************************************************

  logic [`P3S_LINREG_W-1:0] linreg_q, linreg_d;
  logic [`P3S_CONV_W-1:0] conv_q, conv_d;
  logic [`P3S_DATA_W-1:0] rdata_q, rdata_d;
  logic ready_q, ready_d;

  // The reserved bits are tied off in the read path rather than stored, so
  // no write can ever make them read back as one.
  function automatic logic [`P3S_DATA_W-1:0] read_word(
    input logic [`P3S_ADDR_W-1:0] addr,
    input logic [`P3S_LINREG_W-1:0] lin,
    input logic [`P3S_CONV_W-1:0] conv
  );
    logic [`P3S_DATA_W-1:0] word;
    word = `P3S_RD_UNMAPPED;
    if (addr == `P3S_ADDR_LINREG) begin
      word = lin;
    end else if (addr == `P3S_ADDR_CONV) begin
      word = {`P3S_RSVD_BITS, conv};
    end
    return word;
  endfunction

  // Writes are refused until the defaults have landed, so that the load
  // pulse cannot silently overwrite what software has just written.
  always_comb begin
    linreg_d = linreg_q;
    conv_d = conv_q;
    rdata_d = rdata_q;
    ready_d = done;
    if (load) begin
      linreg_d = def_linreg;
      conv_d = def_conv;
    end else if (done && WR_I) begin
      if (ADDR_I == `P3S_ADDR_LINREG) begin
        linreg_d = WDATA_I;
      end else if (ADDR_I == `P3S_ADDR_CONV) begin
        conv_d = WDATA_I[`P3S_CONV_W-1:0];
      end
    end
    if (RD_I) begin
      rdata_d = read_word(ADDR_I, linreg_q, conv_q);
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      linreg_q <= `P3S_RST_LINREG;
      conv_q <= `P3S_RST_CONV;
      rdata_q <= `P3S_RD_UNMAPPED;
      ready_q <= 1'b0;
    end else begin
      linreg_q <= linreg_d;
      conv_q <= conv_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
    end
  end

  // ***********************************************************************
  // Outputs
  // ***********************************************************************

  assign LINREG_PIN3_SEL_O = linreg_q;
  assign CONV_PIN3_SEL_O = conv_q;
  assign RDATA_O = rdata_q;
  assign READY_O = ready_q;

  // ***********************************************************************
  // Checks
  // ***********************************************************************

  a_write_linreg_sel: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    (done && !load && WR_I && ADDR_I == `P3S_ADDR_LINREG)
      |=> (LINREG_PIN3_SEL_O == $past(WDATA_I)) && $stable(CONV_PIN3_SEL_O))
    else $error("Linear regulator select write did not land.");

  a_write_conv_sel: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    (done && !load && WR_I && ADDR_I == `P3S_ADDR_CONV)
      |=> (CONV_PIN3_SEL_O == $past(WDATA_I[`P3S_CONV_W-1:0])) && $stable(LINREG_PIN3_SEL_O))
    else $error("Converter select write did not land.");

  a_rsvd_read_zero: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    (RD_I && ADDR_I == `P3S_ADDR_CONV)
      |=> RDATA_O == {`P3S_RSVD_BITS, $past(conv_q)})
    else $error("Converter select read returned wrong or nonzero reserved bits.");

  a_reset_defaults: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    (!done && !load) |-> (linreg_q == `P3S_RST_LINREG && conv_q == `P3S_RST_CONV && !READY_O))
    else $error("Select registers left their reset contents before loading.");

  a_otp_apply: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    load |=> (linreg_q == $past(def_linreg) && conv_q == $past(def_conv)) ##1 READY_O)
    else $error("Factory defaults were not applied before ready.");

  a_hold_idle: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    (!load && !WR_I) |=> ($stable(linreg_q) && $stable(conv_q)))
    else $error("Select registers changed without a write or load.");

  a_early_write_drop: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    (!done && !load && WR_I)
      |=> ($stable(LINREG_PIN3_SEL_O) && $stable(CONV_PIN3_SEL_O)))
    else $error("A write landed before the defaults were loaded.");

  a_unmapped_write: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    (WR_I && ADDR_I != `P3S_ADDR_LINREG && ADDR_I != `P3S_ADDR_CONV && !load)
      |=> ($stable(LINREG_PIN3_SEL_O) && $stable(CONV_PIN3_SEL_O)))
    else $error("A write to an unmapped address changed a select register.");

  a_load_pulse_once: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    load |=> !load)
    else $error("Default load pulse lasted more than one cycle.");

  a_ready_waits_done: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    !done |=> !READY_O)
    else $error("Ready rose before the defaults were loaded.");

  a_ready_after_load: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    $rose(READY_O) |-> $past(load, 2))
    else $error("Ready rose without a default load two cycles earlier.");

  a_ready_stays: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    READY_O |=> READY_O)
    else $error("Ready dropped without a reset.");

  // ***********************************************************************
  // Read path checks
  // ***********************************************************************

  a_lin_read_back: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    (RD_I && ADDR_I == `P3S_ADDR_LINREG)
      |=> RDATA_O == $past(LINREG_PIN3_SEL_O))
    else $error("Linear regulator select read returned the wrong byte.");

  a_rsvd_bits_low: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    (RD_I && ADDR_I == `P3S_ADDR_CONV)
      |=> RDATA_O[`P3S_DATA_W-1:`P3S_CONV_W] == `P3S_RSVD_BITS)
    else $error("Reserved bits of the converter select read back nonzero.");

  a_rdata_hold: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    !RD_I |=> $stable(RDATA_O))
    else $error("Read data changed without a read strobe.");

  a_unmapped_read: assert property (
    @(posedge CLK_I) disable iff (!RESETN_I)
    (RD_I && ADDR_I != `P3S_ADDR_LINREG && ADDR_I != `P3S_ADDR_CONV)
      |=> RDATA_O == `P3S_RD_UNMAPPED)
    else $error("Unmapped read did not return zero.");

endmodule
`default_nettype wire

/* verification/test_pin_three_enable_select_regs.sv */
// Self-checking testbench for the third-enable-pin select register pair.
// Assumes the core/ sources are compiled first and the access port is p3s_regs's own.
`timescale 1ns/1ps
`default_nettype none

module test_pin_three_enable_select_regs;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic rd = 1'b0;
  logic [7:0] otp_lin = 8'h18;
  logic [5:0] otp_conv = 6'h2D;
  logic [7:0] rdata;
  logic ready;
  logic [7:0] lin_sel;
  logic [5:0] conv_sel;
  logic [7:0] seen;
  int fails = 0;
  int tests_run = 0;

  always #2.5 clk = ~clk;

  p3s_regs i_dut (
    .CLK_I(clk),
    .RESETN_I(rstn),
    .ADDR_I(addr),
    .WR_I(wr),
    .WDATA_I(wdata),
    .RD_I(rd),
    .OTP_LINREG_I(otp_lin),
    .OTP_CONV_I(otp_conv),
    .RDATA_O(rdata),
    .READY_O(ready),
    .LINREG_PIN3_SEL_O(lin_sel),
    .CONV_PIN3_SEL_O(conv_sel)
  );

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    seen = rdata;
  endtask

  // Writes before the defaults land are dropped: one early write checks that, the rest waits for ready.
  task automatic power_up;
    @(posedge clk);
    rstn <= 1'b0;
    #1;
    check("lin_rst", lin_sel, 8'h00);
    check("conv_rst", {2'b00, conv_sel}, 8'h00);
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    wr_reg(8'h33, ~otp_lin);
    check("lin_early", lin_sel, 8'h00);
    for (int i = 0; i < 20 && ready !== 1'b1; i++) @(posedge clk);
    #1;
    check("ready", {7'h00, ready}, 8'h01);
    check("lin_def", lin_sel, otp_lin);
    check("conv_def", {2'b00, conv_sel}, {2'b00, otp_conv});
    rd_reg(8'h33);
    check("rd33_def", seen, otp_lin);
    rd_reg(8'h34);
    check("rd34_def", seen, {2'b00, otp_conv});
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    power_up();
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'h33, 8'h01 << i);
      check("lin_bit", lin_sel, 8'h01 << i);
      check("conv_keep", {2'b00, conv_sel}, {2'b00, otp_conv});
      rd_reg(8'h33);
      check("rd33_bit", seen, 8'h01 << i);
    end
    // Bits 7 and 6 must not stick even when written to one.
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'h34, 8'h01 << i);
      check("conv_bit", {2'b00, conv_sel}, (8'h01 << i) & 8'h3F);
      rd_reg(8'h34);
      check("rd34_bit", seen, (8'h01 << i) & 8'h3F);
    end
    wr_reg(8'h35, 8'hFF);
    check("lin_unmap", lin_sel, 8'h80);
    check("conv_unmap", {2'b00, conv_sel}, 8'h00);
    rd_reg(8'h35);
    check("rd35", seen, 8'h00);
    @(posedge clk);
    otp_lin <= 8'hC3;
    otp_conv <= 6'h12;
    power_up();
    conclude();
  end

  initial begin
    #(5 * 2000);
    fails++;
    conclude();
  end
endmodule

`default_nettype wire
